// >>> inc/rifd_defs.vh
// rifd_defs.vh: field positions and widths of the instruction field decoder
// assumes inclusion by bare name from the design file
`ifndef RIFD_DEFS_VH
`define RIFD_DEFS_VH
`define RIFD_OP_HI 31
`define RIFD_OP_LO 24
`define RIFD_F2_HI 23
`define RIFD_F2_LO 16
`define RIFD_F1_HI 15
`define RIFD_F1_LO 8
`define RIFD_F0_HI 7
`define RIFD_F0_LO 0
`define RIFD_SEL_BIT 24
`define RIFD_LDST_W 7
`define RIFD_FS_HI 1
`define RIFD_FS_LO 0
`define RIFD_PC_W 30
`define RIFD_RST_WORD 32'h00000000
`define RIFD_RST_PC 30'h00000000
`define RIFD_RST_BYTE 8'h00
`define RIFD_RST_CTL 7'h00
`define RIFD_RST_HALF 16'h0000
`define RIFD_RST_FMT 2'h0
`define RIFD_RST_BIT 1'b0
`define RIFD_LANE_W 8
`endif

// >>> verilog/rifd_decoder.v
// rifd_decoder.v: splits a 32-bit instruction word into fields, selects
// the second operand, checks add/subtract overflow and forms branch targets.
// assumes fetch presents a word with instr_vld, and operands arrive in the same cycle.
`timescale 1ns/10ps
`default_nettype none
`include "rifd_defs.vh"

module rifd_decoder (
  input wire clk, // core clock, 10 MHz
  input wire rst_n, // asynchronous reset, active low
  input wire instr_vld, // fetch presents a valid instruction word
  input wire [31:0] instr_word, // instruction word from fetch
  input wire [29:0] pc_word, // word address of this instruction
  input wire [31:0] first_operand_val, // contents of the first source register
  input wire [31:0] src_two_reg_val, // contents of the second source register
  input wire sub_sel, // 1: subtract, 0: add, for overflow checks
  output wire [7:0] instr_code_field, // operation code
  output wire pc_rel_or_fixed_sel, // 1: absolute target
  output wire operand_src_bit, // 1: immediate second operand
  output wire [7:0] dest_reg_num, // destination register
  output wire [7:0] src_one_reg_num, // first source register
  output wire [7:0] special_reg_id, // special register number
  output wire [7:0] src_two_reg_num, // second source register
  output wire [7:0] trap_vector_idx, // trap vector number
  output wire [6:0] ld_st_ctl_field, // load/store control
  output wire [15:0] jump_word_addr, // joined jump word address
  output wire [15:0] const16_val, // joined 16-bit constant
  output wire [31:0] second_operand_val, // register or zero-extended constant
  output wire [7:0] format_change_ctl, // conversion control byte
  output wire [1:0] src_format_field, // operand format for class and root
  output wire [29:0] branch_target, // resolved word target
  output wire signed_ovf, // signed overflow
  output wire unsigned_ovf, // unsigned add overflow
  output wire unsigned_unf, // unsigned subtract underflow
  output wire [7:0] dest_paired_reg, // twin of destination register
  output wire [7:0] src_one_paired_reg, // twin of first source register
  output wire [7:0] src_two_paired_reg // twin of second source register
);

////////////////////////////////////////////////////////////////////////////////
// twin lookup is used for three register fields
function [7:0] rifd_twin;
  input [7:0] reg_num;
  begin
    rifd_twin = {reg_num[7:1], ~reg_num[0]};
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// field extraction; reserved bits simply pass and are not interpreted
wire [7:0] op_f = instr_word[`RIFD_OP_HI:`RIFD_OP_LO];
wire [7:0] f2 = instr_word[`RIFD_F2_HI:`RIFD_F2_LO];
wire [7:0] f1 = instr_word[`RIFD_F1_HI:`RIFD_F1_LO];
wire [7:0] f0 = instr_word[`RIFD_F0_HI:`RIFD_F0_LO];
wire sel_f = instr_word[`RIFD_SEL_BIT];

////////////////////////////////////////////////////////////////////////////////
// operand select and arithmetic checks, all combinational
reg [31:0] nxt_opb;
reg [32:0] nxt_sum;
reg nxt_sovf;
reg nxt_uovf;
reg nxt_uunf;
reg [29:0] nxt_target;
reg [15:0] jmp16;

always @*
begin
  if (sel_f)
    nxt_opb = {24'h000000, f0};
  else
    nxt_opb = src_two_reg_val;
  jmp16 = {f2, f0};
  // one adder serves both: subtract is add of the complement plus one
  if (sub_sel)
    nxt_sum = {1'b0, first_operand_val} + {1'b0, ~nxt_opb} + 33'h000000001;
  else
    nxt_sum = {1'b0, first_operand_val} + {1'b0, nxt_opb};
  if (sub_sel)
    nxt_sovf = (first_operand_val[31] != nxt_opb[31]) &&
      (nxt_sum[31] != first_operand_val[31]);
  else
    nxt_sovf = (first_operand_val[31] == nxt_opb[31]) &&
      (nxt_sum[31] != first_operand_val[31]);
  nxt_uovf = !sub_sel && nxt_sum[32];
  nxt_uunf = sub_sel && !nxt_sum[32];
  // word offsets wrap within the 30-bit counter, as the counter itself does
  if (sel_f)
    nxt_target = {14'h0000, jmp16};
  else
    nxt_target = pc_word + {{14{jmp16[15]}}, jmp16};
end

////////////////////////////////////////////////////////////////////////////////
// output stage registers; each loads its next value on every edge
reg [7:0] code_ff;
reg [7:0] nxt_code;
reg abs_sel_ff;
reg nxt_abs_sel;
reg imm_sel_ff;
reg nxt_imm_sel;
reg [7:0] dest_num_ff;
reg [7:0] nxt_dest_num;
reg [7:0] src_one_num_ff;
reg [7:0] nxt_src_one_num;
reg [7:0] spec_id_ff;
reg [7:0] nxt_spec_id;
reg [7:0] src_two_num_ff;
reg [7:0] nxt_src_two_num;
reg [7:0] trap_idx_ff;
reg [7:0] nxt_trap_idx;
reg [6:0] ldst_ctl_ff;
reg [6:0] nxt_ldst_ctl;
reg [15:0] jump_addr_ff;
reg [15:0] nxt_jump_addr;
reg [15:0] const16_ff;
reg [15:0] nxt_const16;
reg [31:0] opnd_b_ff;
reg [31:0] nxt_opnd_b;
reg [7:0] fmt_ctl_ff;
reg [7:0] nxt_fmt_ctl;
reg [1:0] fs_ff;
reg [1:0] nxt_fs;
reg [29:0] target_ff;
reg [29:0] nxt_tgt;
reg sovf_ff;
reg nxt_sovf_flag;
reg uovf_ff;
reg nxt_uovf_flag;
reg uunf_ff;
reg nxt_uunf_flag;

////////////////////////////////////////////////////////////////////////////////
// next values hold unless fetch presents a valid word, so idle cycles keep
// the last decode visible to the datapath
always @*
begin
  nxt_code = code_ff;
  nxt_abs_sel = abs_sel_ff;
  nxt_imm_sel = imm_sel_ff;
  nxt_dest_num = dest_num_ff;
  nxt_src_one_num = src_one_num_ff;
  nxt_spec_id = spec_id_ff;
  nxt_src_two_num = src_two_num_ff;
  nxt_trap_idx = trap_idx_ff;
  nxt_ldst_ctl = ldst_ctl_ff;
  nxt_jump_addr = jump_addr_ff;
  nxt_const16 = const16_ff;
  nxt_opnd_b = opnd_b_ff;
  nxt_fmt_ctl = fmt_ctl_ff;
  nxt_fs = fs_ff;
  nxt_tgt = target_ff;
  nxt_sovf_flag = sovf_ff;
  nxt_uovf_flag = uovf_ff;
  nxt_uunf_flag = uunf_ff;
  if (instr_vld)
  begin
    nxt_code = op_f;
    nxt_abs_sel = sel_f;
    nxt_imm_sel = sel_f;
    nxt_dest_num = f2;
    nxt_src_one_num = f1;
    nxt_spec_id = f1;
    nxt_src_two_num = f0;
    nxt_trap_idx = f2;
    nxt_ldst_ctl = f2[`RIFD_LDST_W-1:0];
    nxt_jump_addr = jmp16;
    nxt_const16 = {f2, f0};
    nxt_opnd_b = nxt_opb;
    nxt_fmt_ctl = f0;
    nxt_fs = f0[`RIFD_FS_HI:`RIFD_FS_LO];
    nxt_tgt = nxt_target;
    nxt_sovf_flag = nxt_sovf;
    nxt_uovf_flag = nxt_uovf;
    nxt_uunf_flag = nxt_uunf;
  end
end

////////////////////////////////////////////////////////////////////////////////
// opcode, select bits and register numbers
always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    code_ff <= `RIFD_RST_BYTE;
    abs_sel_ff <= `RIFD_RST_BIT;
    imm_sel_ff <= `RIFD_RST_BIT;
    dest_num_ff <= `RIFD_RST_BYTE;
    src_one_num_ff <= `RIFD_RST_BYTE;
    spec_id_ff <= `RIFD_RST_BYTE;
    src_two_num_ff <= `RIFD_RST_BYTE;
  end
  else
  begin
    code_ff <= nxt_code;
    abs_sel_ff <= nxt_abs_sel;
    imm_sel_ff <= nxt_imm_sel;
    dest_num_ff <= nxt_dest_num;
    src_one_num_ff <= nxt_src_one_num;
    spec_id_ff <= nxt_spec_id;
    src_two_num_ff <= nxt_src_two_num;
  end
end

////////////////////////////////////////////////////////////////////////////////
// trap, load/store and conversion control fields
always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    trap_idx_ff <= `RIFD_RST_BYTE;
    ldst_ctl_ff <= `RIFD_RST_CTL;
    fmt_ctl_ff <= `RIFD_RST_BYTE;
    fs_ff <= `RIFD_RST_FMT;
  end
  else
  begin
    trap_idx_ff <= nxt_trap_idx;
    ldst_ctl_ff <= nxt_ldst_ctl;
    fmt_ctl_ff <= nxt_fmt_ctl;
    fs_ff <= nxt_fs;
  end
end

////////////////////////////////////////////////////////////////////////////////
// joined 16-bit values and the resolved target
always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    jump_addr_ff <= `RIFD_RST_HALF;
    const16_ff <= `RIFD_RST_HALF;
    target_ff <= `RIFD_RST_PC;
  end
  else
  begin
    jump_addr_ff <= nxt_jump_addr;
    const16_ff <= nxt_const16;
    target_ff <= nxt_tgt;
  end
end

////////////////////////////////////////////////////////////////////////////////
// second operand
always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    opnd_b_ff <= `RIFD_RST_WORD;
  end
  else
  begin
    opnd_b_ff <= nxt_opnd_b;
  end
end

////////////////////////////////////////////////////////////////////////////////
// overflow flags; they reflect the word just loaded, whatever its opcode
always @(posedge clk or negedge rst_n)
begin
  if (!rst_n)
  begin
    sovf_ff <= `RIFD_RST_BIT;
    uovf_ff <= `RIFD_RST_BIT;
    uunf_ff <= `RIFD_RST_BIT;
  end
  else
  begin
    sovf_ff <= nxt_sovf_flag;
    uovf_ff <= nxt_uovf_flag;
    uunf_ff <= nxt_uunf_flag;
  end
end

////////////////////////////////////////////////////////////////////////////////
// one twin register per register lane: 0 second source, 1 first source, 2 dest
genvar g;
generate
  for (g = 0; g < 3; g = g + 1)
  begin : twin_lane
    wire [7:0] lane_num = instr_word[g*`RIFD_LANE_W +: `RIFD_LANE_W];
    reg [7:0] twin_ff;
    wire [7:0] nxt_twin = instr_vld ? rifd_twin(lane_num) : twin_ff;
    always @(posedge clk or negedge rst_n)
    begin
      if (!rst_n)
        twin_ff <= `RIFD_RST_BYTE;
      else
        twin_ff <= nxt_twin;
    end
  end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// outputs straight from the registers
assign instr_code_field = code_ff;
assign pc_rel_or_fixed_sel = abs_sel_ff;
assign operand_src_bit = imm_sel_ff;
assign dest_reg_num = dest_num_ff;
assign src_one_reg_num = src_one_num_ff;
assign special_reg_id = spec_id_ff;
assign src_two_reg_num = src_two_num_ff;
assign trap_vector_idx = trap_idx_ff;
assign ld_st_ctl_field = ldst_ctl_ff;
assign jump_word_addr = jump_addr_ff;
assign const16_val = const16_ff;
assign second_operand_val = opnd_b_ff;
assign format_change_ctl = fmt_ctl_ff;
assign src_format_field = fs_ff;
assign branch_target = target_ff;
assign signed_ovf = sovf_ff;
assign unsigned_ovf = uovf_ff;
assign unsigned_unf = uunf_ff;
assign dest_paired_reg = twin_lane[2].twin_ff;
assign src_one_paired_reg = twin_lane[1].twin_ff;
assign src_two_paired_reg = twin_lane[0].twin_ff;

endmodule
`default_nettype wire

// >>> tb/rifd_rf.sv
// rifd_rf.sv: register file model feeding the second operand
// assumes a combinational read in the fetch cycle
`timescale 1ns/10ps
`default_nettype none
module rifd_rf (
  input wire logic [7:0] num, // register number
  output logic [31:0] val // register contents
);
  // mixed pattern so that byte swaps and shifts show up
  assign val = {num, ~num, num, ~num};
endmodule
`default_nettype wire

// >>> tb/rifd_chk.sv
// rifd_chk.sv: port assertions of the field decoder
// assumes outputs load one edge after instr_vld
`timescale 1ns/10ps
`default_nettype none
module rifd_chk (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic instr_vld, // valid
  input wire logic [31:0] instr_word, // word
  input wire logic [31:0] src_two_reg_val, // reg b
  input wire logic [7:0] instr_code_field, // opcode
  input wire logic [7:0] dest_reg_num, // dest
  input wire logic [7:0] src_two_reg_num, // src two
  input wire logic [31:0] second_operand_val, // b
  input wire logic [6:0] ld_st_ctl_field, // ldst
  input wire logic [7:0] src_one_paired_reg // twin
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  op_field_a: assert property (instr_vld |=> instr_code_field == $past(instr_word[31:24]))
    else $error("opcode");
  dest_field_a: assert property (instr_vld |=> dest_reg_num == $past(instr_word[23:16]))
    else $error("dest");
  src_two_a: assert property (instr_vld |=> src_two_reg_num == $past(instr_word[7:0]))
    else $error("src two");
  imm_zext_a: assert property (instr_vld && instr_word[24] |=>
    second_operand_val == {24'h000000, $past(instr_word[7:0])}) else $error("imm");
  reg_opnd_a: assert property (instr_vld && !instr_word[24] |=>
    second_operand_val == $past(src_two_reg_val)) else $error("reg b");
  ldst_ctl_a: assert property (instr_vld |=> ld_st_ctl_field == $past(instr_word[22:16]))
    else $error("ldst");
  twin_reg_a: assert property (instr_vld |=>
    src_one_paired_reg == ($past(instr_word[15:8]) ^ 8'h01)) else $error("twin");
  hold_out_a: assert property (!instr_vld |=> $stable(instr_code_field))
    else $error("hold");
  cover property (instr_vld && instr_word[24]);
  cover property (instr_vld && !instr_word[24]);
  cover property (instr_vld ##1 !instr_vld);
endmodule
bind rifd_decoder rifd_chk u_chk (.*);
`default_nettype wire

// >>> tb/tb.sv
// tb.sv: directed checks of the field decoder
// assumes 10 MHz clock; one to three words issued per scenario
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 0, rst_n = 0, instr_vld = 0, sub_sel = 0;
  logic [31:0] instr_word = 0, first_operand_val = 0, src_two_reg_val, second_operand_val;
  logic [29:0] pc_word = 30'h3fffffff, branch_target;
  logic [7:0] instr_code_field, dest_reg_num, src_one_reg_num, special_reg_id, src_two_reg_num;
  logic [7:0] trap_vector_idx, format_change_ctl, dest_paired_reg, src_one_paired_reg;
  logic [7:0] src_two_paired_reg;
  logic [15:0] jump_word_addr, const16_val;
  logic [6:0] ld_st_ctl_field;
  logic [1:0] src_format_field;
  logic pc_rel_or_fixed_sel, operand_src_bit, signed_ovf, unsigned_ovf, unsigned_unf;
  int num_errors = 0, n_compared = 0;
  always #50 clk = ~clk;
  rifd_decoder DUT (.*);
  rifd_rf u_rf (.num(instr_word[7:0]), .val(src_two_reg_val));
  ////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (exp !== got)
    begin
      num_errors++;
      $display("ERROR %s exp %h got %h", nm, exp, got);
    end
  endtask
  task issue(input logic [31:0] w, a, input logic s, input logic [29:0] p);
    @(posedge clk);
    instr_vld <= 1'b1;
    instr_word <= w;
    pc_word <= p;
    first_operand_val <= a;
    sub_sel <= s;
    @(posedge clk);
    instr_vld <= 1'b0;
    #1;
  endtask
  task t_imm;
    issue(32'h15a3c4e7, 32'h00000000, 1'b0, 30'h3fffffff);
    chk("op", instr_code_field, 32'h15);
    chk("abs", pc_rel_or_fixed_sel, 32'h1);
    chk("imm", operand_src_bit, 32'h1);
    chk("dest", dest_reg_num, 32'ha3);
    chk("src one", src_one_reg_num, 32'hc4);
    chk("spec", special_reg_id, 32'hc4);
    chk("src two", src_two_reg_num, 32'he7);
    chk("b", second_operand_val, 32'he7);
    chk("jump", jump_word_addr, 32'ha3e7);
    chk("const", const16_val, 32'ha3e7);
    chk("trap", trap_vector_idx, 32'ha3);
    chk("ldst", ld_st_ctl_field, 32'h23);
    chk("fmt", format_change_ctl, 32'he7);
    chk("fs", src_format_field, 32'h3);
    chk("twin d", dest_paired_reg, 32'ha2);
    chk("twin", src_one_paired_reg, 32'hc5);
    chk("twin b", src_two_paired_reg, 32'he6);
    chk("abs tgt", branch_target, 32'ha3e7);
    chk("flags", {unsigned_unf, unsigned_ovf, signed_ovf}, 32'h0);
  endtask
  task t_reg;
    // pc near the top so the relative target wraps
    issue(32'h14010203, 32'h7fffffff, 1'b0, 30'h3fffffff);
    chk("b", second_operand_val, 32'h03fc03fc);
    chk("imm", operand_src_bit, 32'h0);
    chk("abs", pc_rel_or_fixed_sel, 32'h0);
    chk("rel", branch_target, 32'h102);
    chk("sovf", signed_ovf, 32'h1);
    chk("uovf", unsigned_ovf, 32'h0);
    chk("unf", unsigned_unf, 32'h0);
    // negative offset from a low counter; odd registers pair downwards
    issue(32'h14ff00fe, 32'h00000000, 1'b0, 30'h00000100);
    chk("rel back", branch_target, 32'hfe);
    chk("twin d", dest_paired_reg, 32'hfe);
    chk("twin b", src_two_paired_reg, 32'hff);
  endtask
  task t_arith;
    issue(32'h14000003, 32'h00000000, 1'b1, 30'h00000000);
    chk("unf", unsigned_unf, 32'h1);
    chk("sovf", signed_ovf, 32'h0);
    chk("uovf", unsigned_ovf, 32'h0);
    issue(32'h15000001, 32'h80000000, 1'b1, 30'h00000000);
    chk("sovf", signed_ovf, 32'h1);
    chk("unf", unsigned_unf, 32'h0);
    issue(32'h15000001, 32'hffffffff, 1'b0, 30'h00000000);
    chk("uovf", unsigned_ovf, 32'h1);
    chk("sovf", signed_ovf, 32'h0);
    // a new word without the valid strobe must not reach the outputs
    @(posedge clk);
    instr_word <= 32'h2c000000;
    @(posedge clk);
    #1;
    chk("hold", instr_code_field, 32'h15);
  endtask
  task t_rst;
    @(posedge clk);
    rst_n <= 1'b0;
    #1;
    chk("rst op", instr_code_field, 32'h0);
    chk("rst b", second_operand_val, 32'h0);
    chk("rst tgt", branch_target, 32'h0);
    chk("rst flags", {unsigned_unf, unsigned_ovf, signed_ovf}, 32'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    issue(32'h2c5a0000, 32'h00000000, 1'b0, 30'h00000000);
    chk("op after rst", instr_code_field, 32'h2c);
  endtask
  task end_sim;
    if (num_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_imm;
    t_reg;
    t_arith;
    t_rst;
    end_sim;
  end
  initial
  begin
    #100000;
    num_errors++;
    end_sim;
  end
endmodule
`default_nettype wire
